// *** core/lastc_chan.sv ***
// per-channel signal loss and drive monitor detectors
// assumes inputs already synchronised, bit enables are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "lastc_params.svh"

module lastc_chan
  import lastc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_bit_en_i,
  input wire logic rx_pulse_i,
  input wire logic tx_bit_en_i,
  input wire logic tx_pulse_i,
  input wire logic analog_los_i,
  input wire logic g775_los_i,
  input wire logic e3_mode_i,
  output logic signal_loss_o,
  output logic drive_monitor_alarm_o
);
  // digital loss state
  logic [7:0] zero_cnt_q, zero_cnt_d; // empty bit run
  logic [4:0] win_cnt_q, win_cnt_d; // density window position
  logic [5:0] ones_cnt_q, ones_cnt_d; // pulses in the window
  logic dlos_q, dlos_d; // digital detector verdict
  // drive monitor state
  logic [7:0] idle_cnt_q, idle_cnt_d; // bit periods without pulse
  logic drv_alm_q, drv_alm_d; // drive monitor verdict
  logic [5:0] ones_inc; // window count including this bit

  // next values of the digital loss detector and drive monitor
  always_comb begin
    zero_cnt_d = zero_cnt_q;
    win_cnt_d = win_cnt_q;
    ones_cnt_d = ones_cnt_q;
    dlos_d = dlos_q;
    idle_cnt_d = idle_cnt_q;
    drv_alm_d = drv_alm_q;
    ones_inc = ones_cnt_q + {5'h00, rx_pulse_i};
    if (rx_bit_en_i) begin
      if (rx_pulse_i) begin
        zero_cnt_d = 8'h00;
      end else if (zero_cnt_q != `LASTC_DLOS_DECL) begin
        zero_cnt_d = zero_cnt_q + 8'h01;
      end
      if (!rx_pulse_i && zero_cnt_q == `LASTC_DLOS_DECL - 8'h01) begin
        dlos_d = 1'b1;
      end
      win_cnt_d = win_cnt_q + 5'h01;
      ones_cnt_d = ones_inc;
      if (win_cnt_q == `LASTC_DLOS_WLAST) begin
        if (dlos_q && ones_inc >= `LASTC_DLOS_DENS) begin
          dlos_d = 1'b0;
        end
        ones_cnt_d = 6'h00;
      end
    end
    if (tx_bit_en_i) begin
      if (tx_pulse_i) begin
        idle_cnt_d = 8'h00;
        drv_alm_d = 1'b0;
      end else if (idle_cnt_q != `LASTC_DRV_DECL) begin
        idle_cnt_d = idle_cnt_q + 8'h01;
        if (idle_cnt_q == `LASTC_DRV_DECL - 8'h01) begin
          drv_alm_d = 1'b1;
        end
      end
    end
  end

  // detector registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      zero_cnt_q <= 8'h00;
      win_cnt_q <= 5'h00;
      ones_cnt_q <= 6'h00;
      dlos_q <= 1'b0;
      idle_cnt_q <= 8'h00;
      drv_alm_q <= 1'b0;
    end else begin
      zero_cnt_q <= zero_cnt_d;
      win_cnt_q <= win_cnt_d;
      ones_cnt_q <= ones_cnt_d;
      dlos_q <= dlos_d;
      idle_cnt_q <= idle_cnt_d;
      drv_alm_q <= drv_alm_d;
    end
  end

  assign signal_loss_o = e3_mode_i ? g775_los_i : (dlos_q | analog_los_i);
  assign drive_monitor_alarm_o = drv_alm_q;
endmodule

`default_nettype wire

// *** core/lastc_params.svh ***
// constants for the line alarm status and transmit control block
// assumes a 200 MHz core clock and twelve line channels
`ifndef LASTC_PARAMS_SVH
`define LASTC_PARAMS_SVH

// channel count
`define LASTC_NCH 12
// low nibble of the register index selects the register kind
`define LASTC_LO_ALARM 4'h3
`define LASTC_LO_TXCTL 4'h4
`define LASTC_LO_IRQ 4'h5
`define LASTC_LO_MASK 4'h6
`define LASTC_LO_MODE 4'h7
// alarm status field positions (also irq status and mask)
`define LASTC_ALM_DRV 0
`define LASTC_ALM_SIG 1
`define LASTC_ALM_LCK 2
// transmit control field positions
`define LASTC_TXC_LEV 0
`define LASTC_TXC_INV 1
`define LASTC_TXC_AOS 2
`define LASTC_TXC_PRBS 4
`define LASTC_TXC_MON 5
`define LASTC_TXC_WMASK 8'h37
`define LASTC_TXC_RST 8'h00
// mode register: bit 0 selects e3 operation
`define LASTC_MODE_E3 0
// lock loss: reference edges per window and 0.5 percent of it
`define LASTC_LCK_WIN 11'h3E8
`define LASTC_LCK_TOL 11'h005
`define LASTC_LCK_LAST 10'h3E7
// digital signal loss: empty run, density window, density figure
`define LASTC_DLOS_DECL 8'hA0
`define LASTC_DLOS_WLAST 5'h1F
`define LASTC_DLOS_DENS 6'h0B
// drive monitor empty run
`define LASTC_DRV_DECL 8'h80
// positions of the pin inputs in the per-channel sync vector
`define LASTC_SY_REC 0
`define LASTC_SY_REF 1
`define LASTC_SY_TXC 2
`define LASTC_SY_RXP 3
`define LASTC_SY_RXN 4
`define LASTC_SY_TPP 5
`define LASTC_SY_TPN 6
`define LASTC_SY_MP 7
`define LASTC_SY_MN 8
`define LASTC_SY_ALOS 9
`define LASTC_SY_GLOS 10
`define LASTC_SY_W 11

`endif

// *** core/lastc_pkg.sv ***
// types for the line alarm status and transmit control block
// assumes lastc_params.svh is on the include path
package lastc_pkg;
  // register kinds found by the address decoder
  typedef enum logic [2:0] {
    REG_NONE,
    REG_ALARM,
    REG_TXCTL,
    REG_IRQ,
    REG_MASK,
    REG_MODE
  } lastc_reg_t;
  // one register byte
  typedef logic [7:0] lastc_byte_t;
endpackage

// *** core/lastc_top.sv ***
// twelve-channel alarm status and transmit control register bank
// assumes a classic wishbone master on core_clk_i and asynchronous
// line pins, which are synchronised here before use
`timescale 1ns/1ps
`default_nettype none
`include "lastc_params.svh"

module lastc_top
  import lastc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // line side pins, one bit per channel
  input wire logic [11:0] rec_clk_i,
  input wire logic [11:0] ref_clk_i,
  input wire logic [11:0] tx_clk_i,
  input wire logic [11:0] rx_pos_i,
  input wire logic [11:0] rx_neg_i,
  input wire logic [11:0] tx_pos_out_i,
  input wire logic [11:0] tx_neg_out_i,
  input wire logic [11:0] monitor_pos_in_i,
  input wire logic [11:0] monitor_neg_in_i,
  input wire logic [11:0] analog_los_i,
  input wire logic [11:0] g775_los_i,
  // transmit controls per channel
  output logic [11:0] tx_all_ones_o,
  output logic [11:0] tx_clock_invert_o,
  output logic [11:0] tx_line_level_o,
  output logic [11:0] prbs_err_insert_o,
  // interrupt
  output logic irq_o
);
  localparam int NCH = `LASTC_NCH;

  // map the upper address nibble to a channel number
  function automatic logic [3:0] chan_of(input logic [3:0] code);
    chan_of = (code < 4'h6) ? code : code - 4'h2;
  endfunction

  // upper nibble codes 0-5 and 8-d are channels
  function automatic logic chan_ok(input logic [3:0] code);
    chan_ok = (code < 4'h6) || (code >= 4'h8 && code <= 4'hD);
  endfunction

  // pin synchroniser stages and edge history
  logic [11:0][10:0] raw; // pins gathered per channel
  logic [11:0][10:0] sy1_q; // first stage, read only by sy2
  logic [11:0][10:0] sy2_q; // second stage, safe to use
  logic [11:0][2:0] clk_prev_q; // last rec, ref, tx clock levels
  logic [11:0] rec_rise, ref_rise, tx_rise;
  logic [11:0] rx_pulse, tx_pulse;

  // lock loss counters
  logic [11:0][9:0] ref_cnt_q, ref_cnt_d; // reference edges
  logic [11:0][10:0] rec_cnt_q, rec_cnt_d; // recovered edges
  logic [11:0] lck_q, lck_d; // lock loss verdict

  // detector outputs and register state
  logic [11:0] sig_w, drv_w; // signal loss and drive alarm per channel
  logic [11:0][2:0] alarm_q, alarm_d; // live alarm status
  logic [11:0][2:0] irq_q, irq_d; // sticky alarm rises
  logic [11:0][2:0] mask_q, mask_d; // interrupt enables
  logic [11:0][7:0] txc_q, txc_d; // transmit control
  logic [11:0] mode_q, mode_d; // e3 selection
  logic [11:0] ins_prev_q; // last insert-error bit
  logic [11:0] ins_pulse_q, ins_pulse_d;

  // bus state
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic req; // new request seen this cycle
  lastc_reg_t kind; // decoded register kind
  logic [3:0] ch; // decoded channel

  // gather pins into one vector per channel
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      raw[i] = '0;
      raw[i][`LASTC_SY_REC] = rec_clk_i[i];
      raw[i][`LASTC_SY_REF] = ref_clk_i[i];
      raw[i][`LASTC_SY_TXC] = tx_clk_i[i];
      raw[i][`LASTC_SY_RXP] = rx_pos_i[i];
      raw[i][`LASTC_SY_RXN] = rx_neg_i[i];
      raw[i][`LASTC_SY_TPP] = tx_pos_out_i[i];
      raw[i][`LASTC_SY_TPN] = tx_neg_out_i[i];
      raw[i][`LASTC_SY_MP] = monitor_pos_in_i[i];
      raw[i][`LASTC_SY_MN] = monitor_neg_in_i[i];
      raw[i][`LASTC_SY_ALOS] = analog_los_i[i];
      raw[i][`LASTC_SY_GLOS] = g775_los_i[i];
    end
  end

  // two-flop synchronisers plus clock edge history
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sy1_q <= '0;
      sy2_q <= '0;
      clk_prev_q <= '0;
    end else begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
      for (int i = 0; i < NCH; i++) begin
        clk_prev_q[i] <= sy2_q[i][2:0];
      end
    end
  end

  // edges and pulse observations from synchronised pins
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rec_rise[i] = sy2_q[i][`LASTC_SY_REC] & ~clk_prev_q[i][0];
      ref_rise[i] = sy2_q[i][`LASTC_SY_REF] & ~clk_prev_q[i][1];
      tx_rise[i] = sy2_q[i][`LASTC_SY_TXC] & ~clk_prev_q[i][2];
      rx_pulse[i] = sy2_q[i][`LASTC_SY_RXP] | sy2_q[i][`LASTC_SY_RXN];
      if (txc_q[i][`LASTC_TXC_MON]) begin
        tx_pulse[i] = sy2_q[i][`LASTC_SY_TPP] | sy2_q[i][`LASTC_SY_TPN];
      end else begin
        tx_pulse[i] = sy2_q[i][`LASTC_SY_MP] | sy2_q[i][`LASTC_SY_MN];
      end
    end
  end

  // lock loss: count recovered edges over a window of reference edges
  always_comb begin
    ref_cnt_d = ref_cnt_q;
    rec_cnt_d = rec_cnt_q;
    lck_d = lck_q;
    for (int i = 0; i < NCH; i++) begin
      // saturating recovered edge count
      if (rec_rise[i] && rec_cnt_q[i] != 11'h7FF) begin
        rec_cnt_d[i] = rec_cnt_q[i] + 11'h001;
      end
      if (ref_rise[i]) begin
        if (ref_cnt_q[i] == `LASTC_LCK_LAST) begin
          lck_d[i] = (rec_cnt_q[i] >= `LASTC_LCK_WIN + `LASTC_LCK_TOL) ||
                     (rec_cnt_q[i] <= `LASTC_LCK_WIN - `LASTC_LCK_TOL);
          ref_cnt_d[i] = 10'h000;
          rec_cnt_d[i] = {10'h000, rec_rise[i]};
        end else begin
          ref_cnt_d[i] = ref_cnt_q[i] + 10'h001;
        end
      end
    end
  end

  // lock loss registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref_cnt_q <= '0;
      rec_cnt_q <= '0;
      lck_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_d;
      rec_cnt_q <= rec_cnt_d;
      lck_q <= lck_d;
    end
  end

  // one detector pair per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    lastc_chan u_chan (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .rx_bit_en_i(rec_rise[g]),
      .rx_pulse_i(rx_pulse[g]),
      .tx_bit_en_i(tx_rise[g]),
      .tx_pulse_i(tx_pulse[g]),
      .analog_los_i(sy2_q[g][`LASTC_SY_ALOS]),
      .g775_los_i(sy2_q[g][`LASTC_SY_GLOS]),
      .e3_mode_i(mode_q[g]),
      .signal_loss_o(sig_w[g]),
      .drive_monitor_alarm_o(drv_w[g])
    );
  end

  // address decode: index is the byte address over four
  always_comb begin
    ch = chan_of(wb_adr_i[9:6]);
    kind = REG_NONE;
    if (chan_ok(wb_adr_i[9:6])) begin
      case (wb_adr_i[5:2])
        `LASTC_LO_ALARM: kind = REG_ALARM;
        `LASTC_LO_TXCTL: kind = REG_TXCTL;
        `LASTC_LO_IRQ: kind = REG_IRQ;
        `LASTC_LO_MASK: kind = REG_MASK;
        `LASTC_LO_MODE: kind = REG_MODE;
        default: kind = REG_NONE;
      endcase
    end
  end

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  // register file next values
  always_comb begin
    ack_d = req;
    // read data stands only in the ack cycle, zero otherwise
    dat_d = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      alarm_d[i][`LASTC_ALM_DRV] = drv_w[i];
      alarm_d[i][`LASTC_ALM_SIG] = sig_w[i];
      alarm_d[i][`LASTC_ALM_LCK] = lck_q[i];
    end
    irq_d = irq_q;
    mask_d = mask_q;
    txc_d = txc_q;
    mode_d = mode_q;
    // read data, unmapped reads return zero
    if (req && !wb_we_i) begin
      case (kind)
        REG_ALARM: dat_d = {29'h0000_0000, alarm_q[ch]};
        REG_TXCTL: dat_d = {24'h00_0000, txc_q[ch]};
        REG_IRQ: dat_d = {29'h0000_0000, irq_q[ch]};
        REG_MASK: dat_d = {29'h0000_0000, mask_q[ch]};
        REG_MODE: dat_d = {31'h0000_0000, mode_q[ch]};
        default: dat_d = 32'h0000_0000;
      endcase
      // reading the sticky register clears it
      if (kind == REG_IRQ) begin
        irq_d[ch] = 3'h0;
      end
    end
    // writes; status ignores them
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (kind)
        REG_TXCTL: txc_d[ch] = wb_dat_i[7:0] & `LASTC_TXC_WMASK;
        REG_MASK: mask_d[ch] = wb_dat_i[2:0];
        REG_MODE: mode_d[ch] = wb_dat_i[`LASTC_MODE_E3];
        default: mode_d = mode_q;
      endcase
    end
    // new alarm rises set sticky bits, winning over a read clear
    for (int i = 0; i < NCH; i++) begin
      irq_d[i] = irq_d[i] | (alarm_d[i] & ~alarm_q[i]);
    end
    for (int i = 0; i < NCH; i++) begin
      ins_pulse_d[i] = txc_q[i][`LASTC_TXC_PRBS] & ~ins_prev_q[i];
    end
  end

  // register file flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      alarm_q <= '0;
      irq_q <= '0;
      mask_q <= '0;
      txc_q <= {NCH{`LASTC_TXC_RST}};
      mode_q <= '0;
      ins_prev_q <= '0;
      ins_pulse_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      alarm_q <= alarm_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
      txc_q <= txc_d;
      mode_q <= mode_d;
      for (int i = 0; i < NCH; i++) begin
        ins_prev_q[i] <= txc_q[i][`LASTC_TXC_PRBS];
      end
      ins_pulse_q <= ins_pulse_d;
    end
  end

  // outputs, all from flops except the interrupt reduction
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign prbs_err_insert_o = ins_pulse_q;
  always_comb begin
    irq_o = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      tx_all_ones_o[i] = txc_q[i][`LASTC_TXC_AOS];
      tx_clock_invert_o[i] = txc_q[i][`LASTC_TXC_INV];
      tx_line_level_o[i] = txc_q[i][`LASTC_TXC_LEV];
      irq_o = irq_o | (|(irq_q[i] & mask_q[i]));
    end
  end
endmodule

`default_nettype wire

// *** dv/lastc_asserts.sv ***
// checker for the bank bus answers and control outputs
// assumes it is bound onto lastc_top, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module lastc_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [11:0] tx_line_level_o,
  input wire logic [11:0] prbs_err_insert_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // request not yet answered
  logic req;
  // answered read, and its register kind
  logic rdk;
  logic [3:0] kind;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdk = wb_ack_o && !wb_we_i;
  assign kind = wb_adr_i[5:2];
  property p_ack_next; req |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("dat idle");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("dat high");
  property p_rsv; rdk && kind == 4'h4 |-> !wb_dat_o[7] && !wb_dat_o[6]
    && !wb_dat_o[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_sts; rdk && kind == 4'h3 |-> wb_dat_o[7:3] == 5'h00; endproperty
  a_sts: assert property (p_sts) else $error("status high");
  property p_lev_wr; req && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] ==
    8'h04 |=> tx_line_level_o[0] == $past(wb_dat_i[0]); endproperty
  a_lev_wr: assert property (p_lev_wr) else $error("level bad");
  property p_ins; prbs_err_insert_o[0] |=> !prbs_err_insert_o[0]; endproperty
  a_ins: assert property (p_ins) else $error("insert long");
endmodule
bind lastc_top lastc_asserts u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_line_level_o(tx_line_level_o),
  .prbs_err_insert_o(prbs_err_insert_o)
);
`default_nettype wire

// *** dv/lastc_line_model.sv ***
// line side model: bit clocks and bipolar rails, all channels
// assumes 40 ns bit periods, far slower than the core clock
`timescale 1ns/1ps
`default_nettype none
module lastc_line_model (
  input wire logic [1:0] rec_sel_i,
  input wire logic rx_on_i,
  input wire logic pad_on_i,
  input wire logic mon_on_i,
  output logic [11:0] rec_clk_o,
  output logic [11:0] ref_clk_o,
  output logic [11:0] rx_pos_o,
  output logic [11:0] rx_neg_o,
  output logic [11:0] pad_pos_o,
  output logic [11:0] pad_neg_o,
  output logic [11:0] mon_pos_o,
  output logic [11:0] mon_neg_o
);
  // reference and recovered clocks, mark polarity
  logic ref_c = 1'b0;
  logic rec_c = 1'b0;
  logic pol_r = 1'b0;
  logic pol_t = 1'b0;
  always #20 ref_c = !ref_c;
  // recovered clock slow by 0, 0.3 or 0.6 percent
  always begin
    #(rec_sel_i == 2'h2 ? 20.12 : rec_sel_i == 2'h1 ? 20.06 : 20.0);
    rec_c = !rec_c;
  end
  // marks change on the fall so they are stable at the rise
  always @(negedge rec_c) pol_r <= !pol_r;
  always @(negedge ref_c) pol_t <= !pol_t;
  assign ref_clk_o = {12{ref_c}};
  assign rec_clk_o = {12{rec_c}};
  assign rx_pos_o = {12{rx_on_i & pol_r}};
  assign rx_neg_o = {12{rx_on_i & !pol_r}};
  assign pad_pos_o = {12{pad_on_i & pol_t}};
  assign pad_neg_o = {12{pad_on_i & !pol_t}};
  assign mon_pos_o = {12{mon_on_i & pol_t}};
  assign mon_neg_o = {12{mon_on_i & !pol_t}};
endmodule
`default_nettype wire

// *** dv/lastc_top_tb.sv ***
// bench for the alarm status and transmit control bank
// assumes the line model drives every channel alike
`timescale 1ns/1ps
`default_nettype none
module lastc_top_tb;
  import lastc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  // bus master side
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  // byte lanes driven, and lanes wanted by the next request
  logic [3:0] sel = 4'h1, sel_v = 4'h1;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, irq;
  // line controls
  logic [1:0] rsel = 2'h0;
  logic rx_on = 1'b1, pad_on = 1'b1, mon_on = 1'b1;
  logic [11:0] alos = 12'h000, glos = 12'h000;
  logic [11:0] rec, rfc, rxp, rxn, tpp, tpn, mp, mn, aos, inv, lev, ins;
  int err_count = 0;
  int tests_run = 0;
  int ins_cnt = 0;
  always #2.5 clk = !clk;
  // insert pulses seen on channel 0
  always @(posedge clk) if (ins[0] === 1'b1) ins_cnt++;
  lastc_line_model u_line (
    .rec_sel_i(rsel), .rx_on_i(rx_on), .pad_on_i(pad_on), .mon_on_i(mon_on),
    .rec_clk_o(rec), .ref_clk_o(rfc), .rx_pos_o(rxp), .rx_neg_o(rxn),
    .pad_pos_o(tpp), .pad_neg_o(tpn), .mon_pos_o(mp), .mon_neg_o(mn)
  );
  lastc_top u_dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rec_clk_i(rec), .ref_clk_i(rfc),
    .tx_clk_i(rfc), .rx_pos_i(rxp), .rx_neg_i(rxn), .tx_pos_out_i(tpp),
    .tx_neg_out_i(tpn), .monitor_pos_in_i(mp), .monitor_neg_in_i(mn),
    .analog_los_i(alos), .g775_los_i(glos), .tx_all_ones_o(aos),
    .tx_clock_invert_o(inv), .tx_line_level_o(lev),
    .prbs_err_insert_o(ins), .irq_o(irq)
  );
  task automatic wrap_up();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] i, input lastc_byte_t d,
                    output lastc_byte_t q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_v;
    adr <= {i, 2'b00};
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // no answer within the bound ends the run as a failure
    if (ack !== 1'b1) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] i, input lastc_byte_t d);
    lastc_byte_t q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] i,
                    input lastc_byte_t e);
    lastc_byte_t q;
    wb(1'b0, i, 8'h00, q);
    chk(nm, {24'h00_0000, q}, {24'h00_0000, e});
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // control fields, reserved bits, unmapped and read-only places
  task automatic t_regs();
    rd("txc rst", 8'hD4, 8'h00);
    wr(8'hD4, 8'hFF);
    rd("txc rw", 8'hD4, 8'h37);
    chk("pins", {aos[11], inv[11], lev[11]}, 3'h7);
    wr(8'hD4, 8'h00);
    chk("pins 0", {aos[11], inv[11], lev[11]}, 3'h0);
    // a write with lane 0 off leaves the register alone
    sel_v = 4'h0;
    wr(8'hD4, 8'h15);
    sel_v = 4'h1;
    rd("sel off", 8'hD4, 8'h00);
    rd("unmap", 8'h63, 8'h00);
    wr(8'h03, 8'hFF);
    rd("sts ro", 8'h03, 8'h00);
    wr(8'h04, 8'h10);
    wr(8'h04, 8'h10);
    hold(2);
    chk("ins 1", ins_cnt, 1);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h10);
    hold(2);
    chk("ins 2", ins_cnt, 2);
  endtask
  // drive monitor source, declare count and clearing
  task automatic t_drive();
    wr(8'h04, 8'h20);
    mon_on <= 1'b0;
    hold(1200);
    rd("pads", 8'h03, 8'h00);
    wr(8'h04, 8'h00);
    hold(800);
    rd("drv 100", 8'h03, 8'h00);
    hold(400);
    rd("drv 150", 8'h03, 8'h01);
    mon_on <= 1'b1;
    hold(30);
    rd("drv clr", 8'h03, 8'h00);
  endtask
  // signal loss sources, channel map, interrupt and e3 mode
  task automatic t_signal();
    rx_on <= 1'b0;
    hold(1150);
    rd("sig 144", 8'h03, 8'h00);
    hold(200);
    rd("sig 169", 8'h03, 8'h02);
    rx_on <= 1'b1;
    hold(600);
    rd("sig clr", 8'h03, 8'h00);
    alos <= 12'h040;
    hold(8);
    rd("ch6", 8'h83, 8'h02);
    rd("ch5", 8'h53, 8'h00);
    chk("irq off", irq, 1'b0);
    wr(8'h86, 8'h02);
    chk("irq on", irq, 1'b1);
    rd("irq sts", 8'h85, 8'h03);
    hold(2);
    chk("irq clr", irq, 1'b0);
    wr(8'h87, 8'h01);
    hold(8);
    rd("e3 ana", 8'h83, 8'h00);
    glos <= 12'h040;
    hold(8);
    rd("e3 det", 8'h83, 8'h02);
    glos <= 12'h000;
    alos <= 12'h000;
    wr(8'h87, 8'h00);
  endtask
  // lock loss at both sides of the half percent limit
  task automatic t_lock();
    rsel <= 2'h1;
    hold(17000);
    rd("lock 0.3", 8'h03, 8'h00);
    rsel <= 2'h2;
    hold(17000);
    rd("lock 0.6", 8'h03, 8'h04);
    rsel <= 2'h0;
    hold(17000);
    rd("lock clr", 8'h03, 8'h00);
  endtask
  initial begin
    hold(20);
    rst_n <= 1'b1;
    hold(40);
    t_regs();
    t_drive();
    t_signal();
    t_lock();
    wrap_up();
  end
endmodule
`default_nettype wire
